// file: rtl/rio_pkg.sv
// Constants and carrier types for the RTC interrupt output logic.
// Assumes one 200 MHz clock; all slow rates arrive as one-cycle ticks.
`default_nettype none
package rio_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned PULSE_CNT_W = 8;
   // Pulse widths counted in ticks of an 8192 Hz enable
   localparam logic [PULSE_CNT_W-1:0] W_8192 = 8'h01;
   localparam logic [PULSE_CNT_W-1:0] W_4096 = 8'h02;
   localparam logic [PULSE_CNT_W-1:0] W_128 = 8'h40;
   localparam logic [PULSE_CNT_W-1:0] W_64 = 8'h80;
   localparam int unsigned TICK_HZ = 8192;
   localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
   localparam int unsigned CD_RELOAD_W = 8;
   localparam logic [CD_RELOAD_W-1:0] CD_RELOAD_ONE = 8'h01;
   localparam logic [CD_RELOAD_W-1:0] CD_RELOAD_STOP = 8'h00;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {CD_SRC_4096, CD_SRC_64, CD_SRC_1, CD_SRC_1_60} rio_cd_src_t;

   typedef struct packed {
      logic second_irq_en;
      logic minute_irq_en;
      logic countdown_irq_en;
      logic [1:0] watchdog_ctrl_field;
      logic alarm_irq_en;
      logic timestamp_irq_en;
      logic switchover_irq_en;
      logic battery_low_irq_en;
      logic timer_pulse_select;
      logic battery_timestamp_link_en;
   } rio_cfg_t;

   typedef struct packed {
      logic sec_min;
      logic countdown;
      logic alarm;
      logic timestamp;
      logic switchover;
   } rio_clr_t;

   typedef struct packed {
      logic sec_min_flag;
      logic countdown_flag;
      logic watchdog_flag;
      logic alarm_flag;
      logic [1:0] timestamp_flags;
      logic switchover_flag;
      logic battery_low_flag;
   } rio_flags_t;
endpackage : rio_pkg
`default_nettype wire

// file: rtl/rio_pulse.sv
// One interrupt pulse generator: starts on a flag set, ends on width or clear.
// Assumes a slow tick enable and a width measured in ticks.
`default_nettype none
module rio_pulse
   import rio_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic tick_i,
   input wire logic start_i,
   input wire logic flag_i,
   input wire logic [PULSE_CNT_W-1:0] width_i,
   output logic active_o
);
   typedef struct packed {
      logic act;
      logic [PULSE_CNT_W-1:0] cnt;
   } rio_pulse_st_t;
   rio_pulse_st_t s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      if (start_i)
      begin
         s_d.act = 1'b1;
         s_d.cnt = width_i;
      end
      else if (s_q.act && !flag_i)
      begin
         s_d.act = 1'b0;
      end
      else if (s_q.act && tick_i)
      begin
         s_d.cnt = s_q.cnt - 8'h01;
         if (s_q.cnt <= 8'h01)
         begin
            s_d.act = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   assign active_o = s_q.act;
endmodule : rio_pulse
`default_nettype wire

// file: rtl/rio_tick.sv
// Divider giving the 8192 Hz one-cycle enable.
// Assumes the system clock of the package.
`default_nettype none
module rio_tick
   import rio_pkg::*;
#(
   parameter int unsigned DIV = TICK_DIV
)
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   output logic tick_o
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } rio_tick_st_t;
   rio_tick_st_t s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == 16'(DIV - 1))
      begin
         s_d.cnt = 16'h0000;
         s_d.tick = 1'b1;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   assign tick_o = s_q.tick;
endmodule : rio_tick
`default_nettype wire

// file: rtl/rio_top.sv
// Interrupt flag keeping and open-drain interrupt output of the RTC.
// Assumes event strobes from the timers, detector and tamper logic are one-cycle pulses.
`default_nettype none
module rio_top
   import rio_pkg::*;
#(
   parameter int unsigned TICK_DIVIDE = TICK_DIV
)
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Configuration
   input wire rio_cfg_t cfg_i,
   input wire rio_cd_src_t cd_src_i,
   input wire logic [CD_RELOAD_W-1:0] cd_reload_i,
   // Events
   input wire logic sec_inc_i,
   input wire logic min_inc_i,
   input wire logic countdown_expire_i,
   input wire logic watchdog_flag_i,
   input wire logic alarm_match_i,
   input wire logic tamper_mid_i,
   input wire logic tamper_gnd_i,
   input wire logic switchover_event_i,
   input wire logic battery_low_i,
   // Host flag clears
   input wire rio_clr_t clr_i,
   // Status and capture
   output rio_flags_t flags_o,
   output logic ts_capture_o,
   // Open-drain pin, low when enabled
   output logic int_pin_o,
   output logic int_pin_oe_o
);
   typedef struct packed {
      rio_flags_t fl;
      logic cap;
      logic oe;
   } rio_st_t;
   rio_st_t s_q, s_d;

   logic tick;
   logic sm_set, cd_set, sm_pulse, cd_pulse;
   logic [PULSE_CNT_W-1:0] cd_width;
   logic sw_take, ts_take, frozen;
   logic any_en, any_act;

   rio_tick #(.DIV(TICK_DIVIDE)) u_tick
   (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .tick_o(tick)
   );

   // ----------------------------------------
   // Flag set terms
   // ----------------------------------------
   always_comb
   begin
      if (cfg_i.second_irq_en)
      begin
         sm_set = sec_inc_i;
      end
      else if (cfg_i.minute_irq_en)
      begin
         sm_set = min_inc_i;
      end
      else
      begin
         sm_set = 1'b0;
      end
      cd_set = countdown_expire_i && (cd_reload_i != CD_RELOAD_STOP);
      // Width depends on source, and on reload value for the 4096 and 64 sources only
      case (cd_src_i)
         CD_SRC_4096: cd_width = (cd_reload_i == CD_RELOAD_ONE) ? W_8192 : W_4096;
         CD_SRC_64: cd_width = (cd_reload_i == CD_RELOAD_ONE) ? W_128 : W_64;
         default: cd_width = W_64;
      endcase
   end

   // Once the flag holds, later switch-overs are dropped, and with the link on tamper edges too
   assign frozen = cfg_i.battery_timestamp_link_en && s_q.fl.switchover_flag;
   assign sw_take = switchover_event_i && !s_q.fl.switchover_flag;
   assign ts_take = (tamper_mid_i || tamper_gnd_i) && !frozen;

   // ----------------------------------------
   // Pulse generators
   // ----------------------------------------
   rio_pulse u_sm_pulse
   (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .tick_i(tick),
      .start_i(sm_set && cfg_i.timer_pulse_select),
      .flag_i(s_q.fl.sec_min_flag && !clr_i.sec_min),
      .width_i(W_64),
      .active_o(sm_pulse)
   );

   rio_pulse u_cd_pulse
   (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .tick_i(tick),
      .start_i(cd_set && cfg_i.timer_pulse_select),
      .flag_i(s_q.fl.countdown_flag && !clr_i.countdown),
      .width_i(cd_width),
      .active_o(cd_pulse)
   );

   // ----------------------------------------
   // Flags, capture and pin
   // ----------------------------------------
   always_comb
   begin
      s_d = s_q;
      // Set wins over a clear in the same cycle
      if (clr_i.sec_min) s_d.fl.sec_min_flag = 1'b0;
      if (sm_set) s_d.fl.sec_min_flag = 1'b1;
      if (clr_i.countdown) s_d.fl.countdown_flag = 1'b0;
      if (cd_set) s_d.fl.countdown_flag = 1'b1;
      if (clr_i.alarm) s_d.fl.alarm_flag = 1'b0;
      if (alarm_match_i) s_d.fl.alarm_flag = 1'b1;
      if (clr_i.timestamp) s_d.fl.timestamp_flags = 2'h0;
      if (ts_take) s_d.fl.timestamp_flags[0] = 1'b1;
      if (ts_take && tamper_gnd_i) s_d.fl.timestamp_flags[1] = 1'b1;
      if (clr_i.switchover) s_d.fl.switchover_flag = 1'b0;
      if (sw_take) s_d.fl.switchover_flag = 1'b1;
      s_d.fl.watchdog_flag = watchdog_flag_i;
      s_d.fl.battery_low_flag = battery_low_i;
      // Switch-over capture only with link on, tamper unless frozen; flag set is this same edge, after the store
      s_d.cap = ts_take || (sw_take && cfg_i.battery_timestamp_link_en);
      any_en = cfg_i.second_irq_en || cfg_i.minute_irq_en || cfg_i.countdown_irq_en
         || (cfg_i.watchdog_ctrl_field != 2'h0) || cfg_i.alarm_irq_en
         || cfg_i.timestamp_irq_en || cfg_i.switchover_irq_en || cfg_i.battery_low_irq_en;
      any_act = 1'b0;
      // Pulse select only matters for the two timer sources
      if (cfg_i.timer_pulse_select)
      begin
         any_act = (sm_pulse && (cfg_i.second_irq_en || cfg_i.minute_irq_en))
            || (cd_pulse && cfg_i.countdown_irq_en);
      end
      else
      begin
         any_act = (s_q.fl.sec_min_flag && (cfg_i.second_irq_en || cfg_i.minute_irq_en))
            || (s_q.fl.countdown_flag && cfg_i.countdown_irq_en);
      end
      any_act = any_act
         || (s_q.fl.watchdog_flag && (cfg_i.watchdog_ctrl_field != 2'h0))
         || (s_q.fl.alarm_flag && cfg_i.alarm_irq_en)
         || ((s_q.fl.timestamp_flags != 2'h0) && cfg_i.timestamp_irq_en)
         || (s_q.fl.switchover_flag && cfg_i.switchover_irq_en)
         || (s_q.fl.battery_low_flag && cfg_i.battery_low_irq_en);
      s_d.oe = any_en && any_act;
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign flags_o = s_q.fl;
   assign ts_capture_o = s_q.cap;
   assign int_pin_o = 1'b0;
   assign int_pin_oe_o = s_q.oe;
endmodule : rio_top
`default_nettype wire

// file: test/rio_host.sv
// Host interrupt input: pull-up on the shared line, falling-edge counter.
// Assumes the block's open-drain pin and enable.
`default_nettype none
module rio_host
(
   input wire logic pin_i,
   input wire logic pin_oe_i,
   output logic irq_b_o,
   output var int irq_count_o = 0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released line floats up through the pull-up
   assign irq_b_o = pin_oe_i ? pin_i : 1'b1;
   always @(negedge irq_b_o)
      irq_count_o <= irq_count_o + 1;
endmodule : rio_host
`default_nettype wire

// file: test/rio_top_asserts.sv
// Port checks for rio_top.
// Assumes one clock and an async active-low reset.
`default_nettype none
module rio_top_asserts
   import rio_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire rio_cfg_t cfg_i,
   input wire logic watchdog_flag_i,
   input wire logic alarm_match_i,
   input wire logic tamper_mid_i,
   input wire logic tamper_gnd_i,
   input wire logic switchover_event_i,
   input wire logic battery_low_i,
   input wire rio_clr_t clr_i,
   input wire rio_flags_t flags_o,
   input wire logic ts_capture_o,
   input wire logic int_pin_o,
   input wire logic int_pin_oe_o
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);
   wire logic link = cfg_i.battery_timestamp_link_en;
   a_pin_low: assert property (int_pin_o == 1'b0) else $error("pin level high");
   a_idle_release: assert property ((cfg_i[10:2] == '0)[*3] |-> !int_pin_oe_o) else $error("idle pin held");
   a_wd_copy: assert property (flags_o.watchdog_flag == $past(watchdog_flag_i)) else $error("wd flag");
   a_bl_copy: assert property (flags_o.battery_low_flag == $past(battery_low_i)) else $error("bl flag");
   a_link_off: assert property (!link && !tamper_mid_i && !tamper_gnd_i |=> !ts_capture_o) else $error("capture");
   a_sw_capture: assert property (link && !flags_o.switchover_flag && switchover_event_i
      |=> ts_capture_o && flags_o.switchover_flag) else $error("no capture");
   a_sw_locked: assert property (link && flags_o.switchover_flag |=> !ts_capture_o) else $error("locked");
   a_msf_never: assert property (!cfg_i.second_irq_en && !cfg_i.minute_irq_en && !flags_o.sec_min_flag
      |=> !flags_o.sec_min_flag) else $error("msf set");
   a_alarm_clear: assert property (clr_i.alarm && !alarm_match_i |=> !flags_o.alarm_flag) else $error("af");
   a_alarm_level: assert property (flags_o.alarm_flag && cfg_i.alarm_irq_en ##1 $stable(cfg_i)
      |-> int_pin_oe_o) else $error("alarm level");
   cover property (ts_capture_o);
   cover property (int_pin_oe_o && cfg_i.timer_pulse_select);
   cover property ($fell(int_pin_oe_o));
endmodule : rio_top_asserts
bind rio_top rio_top_asserts i_rio_top_asserts (.*);
`default_nettype wire

// file: test/test_rio_top.sv
// Bench for rio_top: flag model compared each cycle, then pulse widths.
// Assumes rio_host on the pin and a divider shortened to TD.
`default_nettype none
module test_rio_top
   import rio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TD = 4;
   logic mclk_i = 0;
   logic rst_b_i = 0;
   rio_cfg_t c = '0;
   rio_cd_src_t s = CD_SRC_4096;
   logic [7:0] r = 8'h00;
   logic [8:0] ev = '0;
   logic [8:0] lv;
   rio_clr_t k = '0;
   rio_flags_t f, m;
   logic cap, pin, oe, irq_b, cm, om, lk;
   int irq_n, errors = 0, samples_checked = 0;
   rio_top #(.TICK_DIVIDE(TD)) i_rio_top (.mclk_i, .rst_b_i, .cfg_i(c), .cd_src_i(s), .cd_reload_i(r),
      .sec_inc_i(ev[8]), .min_inc_i(ev[7]), .countdown_expire_i(ev[6]), .watchdog_flag_i(ev[5]),
      .alarm_match_i(ev[4]), .tamper_mid_i(ev[3]), .tamper_gnd_i(ev[2]), .switchover_event_i(ev[1]),
      .battery_low_i(ev[0]), .clr_i(k), .flags_o(f), .ts_capture_o(cap), .int_pin_o(pin), .int_pin_oe_o(oe));
   rio_host i_rio_host (.pin_i(pin), .pin_oe_i(oe), .irq_b_o(irq_b), .irq_count_o(irq_n));
   always #2.5 mclk_i = ~mclk_i;
   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   always @(posedge mclk_i or negedge rst_b_i)
      if (!rst_b_i)
         {m, cm, om} = '0;
      else
      begin
         om = |({c.second_irq_en | c.minute_irq_en, c.countdown_irq_en, |c.watchdog_ctrl_field, c.alarm_irq_en,
            c.timestamp_irq_en, c.timestamp_irq_en, c.switchover_irq_en, c.battery_low_irq_en} & m);
         lk = c.battery_timestamp_link_en & m.switchover_flag;
         cm = (ev[1] & c.battery_timestamp_link_en & !m.switchover_flag) | (!lk & (ev[3] | ev[2]));
         m.timestamp_flags = (k.timestamp ? 2'b00 : m.timestamp_flags) | (lk ? 2'b00 : {ev[2], ev[3] | ev[2]});
         m.sec_min_flag = (m.sec_min_flag & !k.sec_min) | (c.second_irq_en ? ev[8] : c.minute_irq_en & ev[7]);
         m.countdown_flag = (m.countdown_flag & !k.countdown) | (ev[6] & |r);
         m.alarm_flag = (m.alarm_flag & !k.alarm) | ev[4];
         // A switch-over event is refused while the flag already holds
         m.switchover_flag = (m.switchover_flag & !k.switchover) | (ev[1] & !m.switchover_flag);
         {m.watchdog_flag, m.battery_low_flag} = {ev[5], ev[0]};
      end
   always @(negedge mclk_i)
      if (rst_b_i)
      begin
         check(f, m);
         check(cap, cm);
         if (!c.timer_pulse_select)
            check(irq_b, !om);
      end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic fire(input int b);
      ev[b] = 1'b1;
      @(negedge mclk_i);
      ev[b] = 1'b0;
   endtask : fire
   task automatic clear(input rio_clr_t v);
      k = v;
      @(negedge mclk_i);
      k = '0;
   endtask : clear
   // Width in ticks; the free tick may cut up to one tick
   task automatic pulse(input int w);
      int n0, n;
      n0 = irq_n;
      n = 0;
      repeat (40)
         if (!oe) @(negedge mclk_i);
      while (oe && n < 2000)
      begin
         @(negedge mclk_i);
         n++;
      end
      check(n >= (w - 1) * TD && n <= w * TD + 2, 1'b1);
      check(irq_n, n0 + 1);
   endtask : pulse
   task automatic stop_test;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   initial
   begin
      #100us;
      errors++;
      stop_test();
   end
   initial
   begin
      void'($urandom(32'h51A491F6));
      repeat (12) @(negedge mclk_i);
      rst_b_i = 1'b1;
      for (int i = 0; i < 3000; i++)
      begin
         if (i % 300 == 0)
         begin
            c = rio_cfg_t'($urandom);
            c.timer_pulse_select = 1'b0;
            r = 8'($urandom_range(0, 2));
         end
         lv = ev & 9'h021;
         if ($urandom_range(0, 40) == 0)
            lv = lv ^ (9'h021 & 9'($urandom));
         ev = (9'($urandom) & 9'($urandom) & 9'($urandom) & 9'h1DE) | lv;
         k = 5'($urandom) & 5'($urandom) & 5'($urandom);
         @(negedge mclk_i);
      end
      {ev, k, c} = '0;
      repeat (3) @(negedge mclk_i);
      clear(5'h1F);
      c.timer_pulse_select = 1'b1;
      c.second_irq_en = 1'b1;
      fire(8);
      pulse(128);
      clear(5'h10);
      c.second_irq_en = 1'b0;
      c.countdown_irq_en = 1'b1;
      for (int j = 0; j < 8; j++)
      begin
         s = rio_cd_src_t'(j / 2);
         r = 8'(j % 2 + 1);
         fire(6);
         pulse(j < 2 ? j + 1 : j == 2 ? 64 : 128);
         clear(5'h08);
      end
      fire(6);
      repeat (10) @(negedge mclk_i);
      check(oe, 1'b1);
      clear(5'h08);
      repeat (2) @(negedge mclk_i);
      check(oe, 1'b0);
      r = 8'h00;
      fire(6);
      repeat (10) @(negedge mclk_i);
      check(oe, 1'b0);
      // Alarm stays a level even with pulse select high
      c.alarm_irq_en = 1'b1;
      fire(4);
      repeat (2) @(negedge mclk_i);
      check(oe, 1'b1);
      clear(5'h04);
      repeat (2) @(negedge mclk_i);
      check(oe, 1'b0);
      stop_test();
   end
endmodule : test_rio_top
`default_nettype wire
